/* File: rtl/npcr_consts.vh */
`ifndef NPCR_CONSTS_VH
`define NPCR_CONSTS_VH
`define NPCR_CMD_READ 8'h00
`define NPCR_CMD_READ_CONF 8'h30
`define NPCR_CMD_COPYBACK_RD 8'h35
`define NPCR_CMD_CACHE_SEQ 8'h31
`define NPCR_CMD_CACHE_END 8'h3F
`define NPCR_CMD_STATUS 8'h70
`define NPCR_CMD_RESET 8'hFF
`define NPCR_CMD_PROG 8'h80
`define NPCR_CMD_PROG_CONF 8'h10
`define NPCR_CMD_CACHE_PROG 8'h15
`define NPCR_CMD_COL_IN 8'h85
`define NPCR_CMD_ERASE 8'h60
`define NPCR_CMD_ERASE_CONF 8'hD0
`define NPCR_CMD_COL_OUT 8'h05
`define NPCR_CMD_COL_OUT_CONF 8'hE0
`define NPCR_ADDR_CYCLES 3'd4
`define NPCR_OP_PAGE 3'd0
`define NPCR_OP_CACHE_SEQ 3'd1
`define NPCR_OP_CACHE_RND 3'd2
`define NPCR_OP_CACHE_END 3'd3
`define NPCR_OP_COL_CHANGE 3'd4
`define NPCR_OP_STATUS 3'd5
`define NPCR_OP_RESET 3'd6
`define NPCR_OP_COPYBACK 3'd7
`define NPCR_STROBE_CYC 4'd2
`define NPCR_BSY_WAIT_NS 100
`define NPCR_CLK_NS 8
`define NPCR_BSY_WAIT_CYC (`NPCR_BSY_WAIT_NS / `NPCR_CLK_NS)
`define NPCR_ST_CACHE_BITS_HI 6
`define NPCR_ST_CACHE_BITS_LO 5
`endif

/* File: rtl/npcr_fifo.v */
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Small synchronous FIFO for read data.
// -----------------------------------------------------------------
module npcr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] cnt_q;
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  wire push;
  wire pop;
  // Full and empty come straight from the fill count.
  assign in_ready_out = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // Storage has no reset; only pointers and the count need a defined value.
  always @(posedge ref_clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end
  // Pointers wrap because depth is a power of two.
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt_q <= {(AW+1){1'b0}};
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // npcr_fifo

/* File: rtl/npcr_host.v */
`timescale 1ns/1ps
`include "npcr_consts.vh"
// -----------------------------------------------------------------
// Host side sequencer for page and cache reads over the NAND pins.
// -----------------------------------------------------------------
module npcr_host #(
  parameter COL_W = 12,
  parameter ROW_W = 16,
  parameter PAGE_BYTES = 2048
) (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire req_valid_in,
  output reg req_ready_out,
  input wire [2:0] req_op_in,
  input wire [COL_W-1:0] req_col_in,
  input wire [ROW_W-1:0] req_row_in,
  input wire [COL_W:0] req_len_in,
  output wire data_valid_out,
  input wire data_ready_in,
  output wire [7:0] data_out,
  output reg [7:0] status_out,
  output reg done_out,
  output reg chip_en_n_out,
  output reg cmd_latch_out,
  output reg addr_latch_out,
  output reg write_strobe_n_out,
  output reg read_strobe_n_out,
  output reg [7:0] io_out,
  output reg io_oe_n_out,
  input wire [7:0] io_in,
  input wire ready_busy_n_in
);
  // -----------------------------------------------------------------
  // State codes.
  // -----------------------------------------------------------------
  localparam S_IDLE = 4'd0;
  localparam S_CMD1 = 4'd1;
  localparam S_ADDR = 4'd2;
  localparam S_CMD2 = 4'd3;
  localparam S_WAIT = 4'd4;
  localparam S_BUSY = 4'd5;
  localparam S_READ = 4'd6;
  localparam S_STAT = 4'd7;
  localparam S_RECMD = 4'd8;
  localparam BSY_CYC = `NPCR_BSY_WAIT_CYC;
  reg [3:0] st_q;
  reg [2:0] op_q;
  reg [2:0] acnt_q;
  reg [3:0] tcnt_q;
  reg [4:0] wcnt_q;
  reg [COL_W:0] left_q;
  reg [COL_W-1:0] col_q;
  reg [ROW_W-1:0] row_q;
  reg [1:0] rbs_q;
  reg [7:0] ios1_q;
  reg [7:0] ios2_q;
  reg [7:0] cmd1;
  reg [7:0] cmd2;
  reg [7:0] abyte;
  reg fifo_push_q;
  reg [7:0] fifo_d_q;
  reg take_q;
  wire fifo_ready;
  wire rdy;
  wire phase_end;
  // Pins are outside our clock, so both pass two flops first.
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rbs_q <= 2'b00;
      ios1_q <= 8'h00;
      ios2_q <= 8'h00;
    end
    else
    begin
      rbs_q <= {rbs_q[0], ready_busy_n_in};
      ios1_q <= io_in;
      ios2_q <= ios1_q;
    end
  end
  assign rdy = rbs_q[1];
  assign phase_end = (tcnt_q == `NPCR_STROBE_CYC);
  // Command bytes per operation; only defined codes are ever sent.
  always @*
  begin
    cmd1 = `NPCR_CMD_READ;
    cmd2 = `NPCR_CMD_READ_CONF;
    case (op_q)
      `NPCR_OP_CACHE_SEQ: cmd1 = `NPCR_CMD_CACHE_SEQ;
      `NPCR_OP_CACHE_RND: cmd2 = `NPCR_CMD_CACHE_SEQ;
      `NPCR_OP_CACHE_END: cmd1 = `NPCR_CMD_CACHE_END;
      `NPCR_OP_COPYBACK: cmd2 = `NPCR_CMD_COPYBACK_RD;
      `NPCR_OP_STATUS: cmd1 = `NPCR_CMD_STATUS;
      `NPCR_OP_RESET: cmd1 = `NPCR_CMD_RESET;
      `NPCR_OP_COL_CHANGE:
      begin
        cmd1 = `NPCR_CMD_COL_OUT;
        cmd2 = `NPCR_CMD_COL_OUT_CONF;
      end
      default: cmd1 = `NPCR_CMD_READ;
    endcase
  end
  // Address byte order: two column cycles then two row cycles.
  always @*
  begin
    case (acnt_q)
      3'd0: abyte = col_q[7:0];
      3'd1: abyte = {4'h0, col_q[COL_W-1:8]};
      3'd2: abyte = row_q[7:0];
      default: abyte = row_q[15:8];
    endcase
  end
  // -----------------------------------------------------------------
  // Main sequencer.
  // -----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q <= S_IDLE;
      op_q <= 3'd0;
      acnt_q <= 3'd0;
      tcnt_q <= 4'd0;
      wcnt_q <= 5'd0;
      left_q <= {(COL_W+1){1'b0}};
      col_q <= {COL_W{1'b0}};
      row_q <= {ROW_W{1'b0}};
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      status_out <= 8'h00;
      chip_en_n_out <= 1'b1;
      cmd_latch_out <= 1'b0;
      addr_latch_out <= 1'b0;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      io_out <= 8'h00;
      io_oe_n_out <= 1'b1;
      fifo_push_q <= 1'b0;
      fifo_d_q <= 8'h00;
      take_q <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      take_q <= 1'b0;
      // A byte leaves the synchroniser a cycle after its phase and stays offered until the buffer takes it.
      fifo_push_q <= take_q || (fifo_push_q && !fifo_ready);
      if (take_q)
        fifo_d_q <= ios2_q;
      tcnt_q <= phase_end ? 4'd0 : tcnt_q + 4'd1;
      case (st_q)
        S_IDLE:
        begin
          // Device powers up in read mode, so no command is sent first.
          req_ready_out <= rdy;
          tcnt_q <= 4'd0;
          chip_en_n_out <= 1'b1;
          if (req_valid_in && req_ready_out)
          begin
            req_ready_out <= 1'b0;
            op_q <= req_op_in;
            col_q <= req_col_in;
            row_q <= req_row_in;
            left_q <= req_len_in;
            acnt_q <= 3'd0;
            chip_en_n_out <= 1'b0;
            st_q <= S_CMD1;
          end
        end
        S_CMD1:
        begin
          // Command latched on the rising write strobe with latch high.
          cmd_latch_out <= 1'b1;
          io_out <= cmd1;
          io_oe_n_out <= 1'b0;
          write_strobe_n_out <= (tcnt_q == 4'd0) ? 1'b0 : 1'b1;
          if (phase_end)
          begin
            cmd_latch_out <= 1'b0;
            if (op_q == `NPCR_OP_CACHE_SEQ || op_q == `NPCR_OP_CACHE_END || op_q == `NPCR_OP_RESET)
              st_q <= S_WAIT;
            else if (op_q == `NPCR_OP_STATUS)
              st_q <= S_STAT;
            else
              st_q <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          // Column change sends two cycles, page reads four.
          addr_latch_out <= 1'b1;
          io_out <= abyte;
          io_oe_n_out <= 1'b0;
          write_strobe_n_out <= (tcnt_q == 4'd0) ? 1'b0 : 1'b1;
          if (phase_end)
          begin
            acnt_q <= acnt_q + 3'd1;
            if ((op_q == `NPCR_OP_COL_CHANGE && acnt_q == 3'd1) || acnt_q == `NPCR_ADDR_CYCLES - 3'd1)
            begin
              addr_latch_out <= 1'b0;
              st_q <= S_CMD2;
            end
          end
        end
        S_CMD2:
        begin
          cmd_latch_out <= 1'b1;
          io_out <= cmd2;
          io_oe_n_out <= 1'b0;
          write_strobe_n_out <= (tcnt_q == 4'd0) ? 1'b0 : 1'b1;
          if (phase_end)
          begin
            cmd_latch_out <= 1'b0;
            // Cache random reads and copy back restart at column zero; page read and column change keep their own.
            if (op_q != `NPCR_OP_COL_CHANGE)
              col_q <= (op_q == `NPCR_OP_PAGE) ? col_q : {COL_W{1'b0}};
            st_q <= (op_q == `NPCR_OP_COL_CHANGE) ? S_READ : S_WAIT;
          end
        end
        S_WAIT:
        begin
          // Busy may take a while to fall, so wait a fixed time first.
          io_oe_n_out <= 1'b1;
          wcnt_q <= wcnt_q + 5'd1;
          if (wcnt_q == BSY_CYC[4:0])
          begin
            wcnt_q <= 5'd0;
            st_q <= S_BUSY;
          end
        end
        S_BUSY:
        begin
          // Nothing but waiting happens while busy is low.
          if (rdy)
          begin
            if (op_q == `NPCR_OP_RESET || op_q == `NPCR_OP_COPYBACK || left_q == {(COL_W+1){1'b0}})
            begin
              done_out <= 1'b1;
              st_q <= S_IDLE;
            end
            else
              st_q <= S_READ;
            tcnt_q <= 4'd0;
          end
        end
        S_READ:
        begin
          // Each one-cycle strobe pulse yields a byte; a byte still offered holds the next pulse back.
          io_oe_n_out <= 1'b1;
          read_strobe_n_out <= 1'b1;
          if (tcnt_q == 4'd0)
          begin
            if (fifo_ready && !fifo_push_q)
              read_strobe_n_out <= 1'b0;
            else
              tcnt_q <= 4'd0;
          end
          if (phase_end)
          begin
            take_q <= 1'b1;
            col_q <= col_q + 1'b1;
            left_q <= left_q - 1'b1;
            // Stop at the requested length or the end of the page.
            if (left_q == 1 || col_q == PAGE_BYTES - 1)
            begin
              done_out <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        end
        S_STAT:
        begin
          io_oe_n_out <= 1'b1;
          read_strobe_n_out <= (tcnt_q == 4'd0) ? 1'b0 : 1'b1;
          if (phase_end)
          begin
            st_q <= S_RECMD;
            tcnt_q <= 4'd0;
          end
        end
        S_RECMD:
        begin
          // Status bits 6:5 tell cache busy, cache ready, or idle; the byte is through the synchroniser now.
          if (tcnt_q == 4'd0)
            status_out <= ios2_q;
          // A status poll leaves the device in status output, so read mode is restored.
          cmd_latch_out <= 1'b1;
          io_out <= `NPCR_CMD_READ;
          io_oe_n_out <= 1'b0;
          write_strobe_n_out <= (tcnt_q == 4'd0) ? 1'b0 : 1'b1;
          if (phase_end)
          begin
            cmd_latch_out <= 1'b0;
            io_oe_n_out <= 1'b1;
            done_out <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // Read data buffer; a stalled drain holds back the read strobe.
  npcr_fifo #(
    .WIDTH(8),
    .DEPTH(4),
    .AW(2)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(fifo_push_q),
    .in_ready_out(fifo_ready),
    .in_data_in(fifo_d_q),
    .out_valid_out(data_valid_out),
    .out_ready_in(data_ready_in),
    .out_data_out(data_out)
  );
endmodule // npcr_host

/* File: sim/npcr_nand_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Behavioural flash device on the far side of the sequencer.
// ----------------------------------------
module npcr_nand_model #(
  parameter BUSY_NS = 400,
  parameter HOLD_NS = 22
) (
  input wire ce_n_in,
  input wire cle_in,
  input wire ale_in,
  input wire we_n_in,
  input wire re_n_in,
  input wire [7:0] io_in,
  output wire [7:0] io_out,
  output reg ready_busy_n_out
);
  reg [7:0] dout_q;
  reg [7:0] last_q;
  reg [2:0] acnt_q;
  reg [11:0] cola_q;
  reg [11:0] col_q;
  reg [15:0] rowa_q;
  reg [15:0] drow_q;
  reg [15:0] crow_q;
  reg [1:0] st65_q;
  reg stat_q;
  reg drive_q;
  // A released bus shows the inverse of the last byte, so a late sample cannot pass by luck.
  assign io_out = drive_q ? dout_q : ~last_q;
  // Power up ready, idle, in read mode with no command needed.
  initial
  begin
    ready_busy_n_out = 1'b1;
    stat_q = 1'b0;
    st65_q = 2'b11;
    drive_q = 1'b0;
    last_q = 8'h00;
    acnt_q = 3'd0;
    col_q = 12'h000;
    drow_q = 16'h0000;
    crow_q = 16'h0000;
  end
  // Busy window; the latch process blocks meanwhile, so nothing else is taken.
  task busy(input integer ns, input [1:0] s);
    begin
      st65_q = 2'b00;
      ready_busy_n_out = 1'b0;
      #ns;
      ready_busy_n_out = 1'b1;
      st65_q = s;
    end
  endtask
  // Commands and addresses land on the rising write strobe.
  always @(posedge we_n_in)
  begin
    if (!ce_n_in && ale_in)
    begin
      case (acnt_q)
        3'd0: cola_q[7:0] = io_in;
        3'd1: cola_q[11:8] = io_in[3:0];
        3'd2: rowa_q[7:0] = io_in;
        default: rowa_q[15:8] = io_in;
      endcase
      acnt_q = acnt_q + 3'd1;
    end
    else if (!ce_n_in && cle_in)
    begin
      stat_q = (io_in == 8'h70);
      case (io_in)
        8'h30, 8'h35:
        begin
          drow_q = rowa_q;
          crow_q = rowa_q;
          col_q = cola_q;
          busy(BUSY_NS, 2'b11);
        end
        8'h31:
        begin
          crow_q = drow_q;
          col_q = 12'h000;
          drow_q = (acnt_q == 3'd4) ? rowa_q : drow_q + 16'h0001;
          busy(BUSY_NS / 4, 2'b10);
        end
        8'h3F:
        begin
          crow_q = drow_q;
          col_q = 12'h000;
          busy(BUSY_NS / 4, 2'b11);
        end
        8'hE0: col_q = cola_q;
        8'hFF: busy(BUSY_NS / 8, 2'b11);
        default: ;
      endcase
      acnt_q = 3'd0;
    end
  end
  // The falling read strobe puts the next byte on the bus.
  always @(negedge re_n_in)
  begin
    if (!ce_n_in)
    begin
      dout_q = stat_q ? {1'b0, st65_q, 5'h00} : crow_q[7:0] + col_q[7:0];
      drive_q = 1'b1;
    end
  end
  // The rising strobe steps the column outside status output; the byte is held for a while, then let go.
  always @(posedge re_n_in)
  begin
    if (drive_q)
    begin
      col_q = stat_q ? col_q : col_q + 12'h001;
      last_q = dout_q;
      #HOLD_NS;
      if (re_n_in)
        drive_q = 1'b0;
    end
  end
endmodule // npcr_nand_model

/* File: sim/npcr_checker.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Pin protocol checks on the sequencer.
// ----------------------------------------
module npcr_checker (
  input wire ref_clk_in,
  input wire arst_n_in,
  input wire req_valid_in,
  input wire req_ready_out,
  input wire done_out,
  input wire chip_en_n_out,
  input wire cmd_latch_out,
  input wire addr_latch_out,
  input wire write_strobe_n_out,
  input wire read_strobe_n_out,
  input wire [7:0] io_out,
  input wire io_oe_n_out,
  input wire ready_busy_n_in
);
  // One clock domain; every check is void while reset is held.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // Three low samples mean the synchronised copy is low as well.
  sequence s_busy;
    !ready_busy_n_in [*3];
  endsequence
  // A read or cache confirm strobed onto the bus.
  sequence s_confirm;
    !write_strobe_n_out && cmd_latch_out && (io_out == 8'h30 || io_out == 8'h31);
  endsequence
  AST_WS_ONE: assert property ($fell(write_strobe_n_out) |=> write_strobe_n_out)
    else $error("write strobe too long");
  AST_RS_PHASE: assert property ($fell(read_strobe_n_out) |=> read_strobe_n_out [*2])
    else $error("read strobe phase too short");
  AST_LATCH_EXCL: assert property (cmd_latch_out |-> !addr_latch_out)
    else $error("both latch enables high");
  AST_WS_DRV: assert property (!write_strobe_n_out |-> !io_oe_n_out && !chip_en_n_out)
    else $error("write strobe without bus drive");
  AST_RS_REL: assert property (!read_strobe_n_out |-> io_oe_n_out && write_strobe_n_out)
    else $error("read strobe while driving");
  AST_DONE: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  AST_TAKE: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
    else $error("ready stayed after take");
  AST_BUSY_CMD: assert property (s_busy ##0 (!write_strobe_n_out && cmd_latch_out) |-> io_out == 8'h70 || io_out == 8'hFF)
    else $error("command while busy");
  AST_BUSY_RD: assert property (s_busy |=> read_strobe_n_out)
    else $error("read strobe while busy");
  AST_CONF_WAIT: assert property (s_confirm |=> read_strobe_n_out [*8])
    else $error("read strobe too soon after confirm");
endmodule // npcr_checker
bind npcr_host npcr_checker u_chk (
  .ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in),
  .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out),
  .done_out(done_out),
  .chip_en_n_out(chip_en_n_out),
  .cmd_latch_out(cmd_latch_out),
  .addr_latch_out(addr_latch_out),
  .write_strobe_n_out(write_strobe_n_out),
  .read_strobe_n_out(read_strobe_n_out),
  .io_out(io_out),
  .io_oe_n_out(io_oe_n_out),
  .ready_busy_n_in(ready_busy_n_in)
);

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h", $time, a); end end
// ----------------------------------------
// Sequencer against the device model.
// ----------------------------------------
module tb;
  reg ref_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg req_valid_in = 1'b0;
  reg [2:0] req_op_in = 3'd0;
  reg [11:0] req_col_in = 12'h000;
  reg [15:0] req_row_in = 16'h0000;
  reg [12:0] req_len_in = 13'h0000;
  reg data_ready_in = 1'b1;
  wire req_ready_out, data_valid_out, done_out, chip_en_n_out, cmd_latch_out, addr_latch_out;
  wire write_strobe_n_out, read_strobe_n_out, io_oe_n_out, ready_busy_n_in;
  wire [7:0] data_out, status_out, io_out, io_in, dev_io;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  reg [7:0] got [$];
  // The shared bus carries whoever drives it; the device only drives while the host has let go.
  assign io_in = io_oe_n_out ? dev_io : io_out;
  npcr_host u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_op_in(req_op_in), .req_col_in(req_col_in), .req_row_in(req_row_in),
    .req_len_in(req_len_in), .data_valid_out(data_valid_out), .data_ready_in(data_ready_in), .data_out(data_out),
    .status_out(status_out), .done_out(done_out), .chip_en_n_out(chip_en_n_out), .cmd_latch_out(cmd_latch_out),
    .addr_latch_out(addr_latch_out), .write_strobe_n_out(write_strobe_n_out), .read_strobe_n_out(read_strobe_n_out),
    .io_out(io_out), .io_oe_n_out(io_oe_n_out), .io_in(io_in), .ready_busy_n_in(ready_busy_n_in));
  npcr_nand_model u_dev (.ce_n_in(chip_en_n_out), .cle_in(cmd_latch_out), .ale_in(addr_latch_out),
    .we_n_in(write_strobe_n_out), .re_n_in(read_strobe_n_out), .io_in(io_in), .io_out(dev_io),
    .ready_busy_n_out(ready_busy_n_in));
  // Clock of 8 ns.
  always #4 ref_clk_in = ~ref_clk_in;
  // Collect every byte handed over and cut a hang short.
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (data_valid_out && data_ready_in)
      got.push_back(data_out);
    if (cycles == 20000)
    begin
      errors++;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // One request, waiting on ready and done under a bound, then a short drain.
  task do_op(input [2:0] op, input [11:0] col, input [15:0] row, input [12:0] len);
    integer n;
    begin
      n = 0;
      while (req_ready_out !== 1'b1 && n < 2000)
      begin
        @(negedge ref_clk_in);
        n++;
      end
      req_op_in = op;
      req_col_in = col;
      req_row_in = row;
      req_len_in = len;
      req_valid_in = 1'b1;
      @(negedge ref_clk_in);
      req_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < 4000)
      begin
        @(negedge ref_clk_in);
        n++;
      end
      `CHK(n < 4000, 1'b1)
      repeat (6) @(negedge ref_clk_in);
    end
  endtask
  // Bytes from one page run on from the given column.
  task expect_bytes(input [15:0] row, input [11:0] col, input integer n);
    integer i;
    reg [7:0] e;
    begin
      `CHK(got.size(), n)
      for (i = 0; i < n && i < got.size(); i++)
      begin
        e = row[7:0] + col[7:0] + i;
        `CHK(got[i], e)
      end
      got.delete();
    end
  endtask
  // Page read straight after reset while the consumer stalls, so the buffer fills and refuses.
  task t_page;
    begin
      data_ready_in = 1'b0;
      fork
        begin
          repeat (150) @(negedge ref_clk_in);
          data_ready_in = 1'b1;
        end
      join_none
      do_op(3'd0, 12'h00a, 16'h0005, 13'd6);
      expect_bytes(16'h0005, 12'h00a, 6);
    end
  endtask
  // Full cache read run with two status polls, a column change and a closing page read.
  task t_cache;
    begin
      do_op(3'd0, 12'h000, 16'h0008, 13'd0);
      do_op(3'd1, 12'h000, 16'h0000, 13'd3);
      expect_bytes(16'h0008, 12'h000, 3);
      do_op(3'd5, 12'h000, 16'h0000, 13'd0);
      `CHK(status_out[6:5], 2'b10)
      do_op(3'd1, 12'h000, 16'h0000, 13'd2);
      expect_bytes(16'h0009, 12'h000, 2);
      do_op(3'd2, 12'h007, 16'h0014, 13'd2);
      expect_bytes(16'h000a, 12'h000, 2);
      do_op(3'd4, 12'h005, 16'h0000, 13'd2);
      expect_bytes(16'h000a, 12'h005, 2);
      do_op(3'd3, 12'h000, 16'h0000, 13'd2);
      expect_bytes(16'h0014, 12'h000, 2);
      do_op(3'd5, 12'h000, 16'h0000, 13'd0);
      `CHK(status_out[6:5], 2'b11)
      do_op(3'd0, 12'h003, 16'h0002, 13'd2);
      expect_bytes(16'h0002, 12'h003, 2);
    end
  endtask
  // Reset command, then read for copy back, whose page is read out through a column change.
  task t_misc;
    begin
      do_op(3'd6, 12'h000, 16'h0000, 13'd0);
      do_op(3'd7, 12'h001, 16'h0003, 13'd0);
      do_op(3'd4, 12'h001, 16'h0000, 13'd2);
      expect_bytes(16'h0003, 12'h001, 2);
    end
  endtask
  // Reset for five cycles, then the scenarios in turn.
  initial
  begin
    repeat (5) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    t_page;
    t_cache;
    t_misc;
    give_verdict;
  end
endmodule // tb
